/* File: logic/aed_decode.sv */
// Purpose: extend the core address to the internal bus and decode regions
// Assumes: one bus cycle presented per valid strobe, decode is same-cycle
// Notes:   mapping bit and sram base come from the integration config regs
`timescale 1ns/1ps
module aed_decode (
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire logic                         cyc_valid,
  input  wire logic [aed_pkg::CORE_AW-1:0]  core_addr,
  input  wire logic                         core_prog,
  input  wire logic                         core_supv,
  input  wire logic                         core_cpu_space,
  input  wire logic                         vec_fetch,
  input  wire logic [aed_pkg::VEC_W-1:0]    vec_offset,
  input  wire logic                         module_map_select,
  input  wire logic [aed_pkg::BUS_AW-1:0]   sram_base,
  input  wire logic                         sram_enable,
  output logic      [aed_pkg::BUS_AW-1:0]   intermodule_bus_addr,
  output logic      [aed_pkg::FC_W-1:0]     function_code,
  output logic                              sel_module,
  output logic                              sel_sram,
  output logic                              sel_external,
  output logic                              regs_locked,
  output logic      [aed_pkg::BUS_AW-1:0]   reg_base
);
  import aed_pkg::*;

  logic [CORE_AW-1:0] eff_addr;
  logic [BUS_AW-1:0]  bus_addr;
  logic [EXT_W-1:0]   reg_nib;
  aed_region_t        region;
  logic               locked_q;
  logic               locked_d;
  logic               map_eff;

  // every check below runs on this clock and drops out during reset
  default clocking aed_cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // ---------------------------------------------------------------------
  // effective address and extension
  // ---------------------------------------------------------------------
  // vector fetches ignore the core address so vectors cannot move
  always_comb begin
    if (vec_fetch) begin
      eff_addr = {BANK0, vec_offset};
    end else begin
      eff_addr = core_addr;
    end
  end

  // sign-style replication keeps the hole unreachable for free
  assign bus_addr = {{EXT_W{eff_addr[SIGN_BIT]}}, eff_addr};

  // ---------------------------------------------------------------------
  // module register base
  // ---------------------------------------------------------------------
  // a bit set again after clearing stays ignored, the lock wins until reset
  assign map_eff = module_map_select & ~locked_q;
  assign reg_nib = {map_eff, REG_NIB_LOW};

  // once cleared the block sits at 700000, which the core cannot emit
  always_comb begin
    locked_d = locked_q | ~module_map_select;
  end

  // sticky lock flag, only reset clears it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= locked_d;
    end
  end

  // ---------------------------------------------------------------------
  // region decode
  // ---------------------------------------------------------------------
  // registers win over sram, sram over external; same-cycle result
  always_comb begin
    region = AED_REG_NONE;
    if (cyc_valid) begin
      if (bus_addr[BUS_AW-1 -: EXT_W] == reg_nib &&
          (bus_addr[CORE_AW-1:0] & REG_WIN_MASK) == REG_WIN_OFS) begin
        region = AED_REG_MOD;
      end else if (sram_enable &&
          (bus_addr & SRAM_MASK) == (sram_base & SRAM_MASK)) begin
        region = AED_REG_SRAM;
      end else begin
        region = AED_REG_EXT;
      end
    end
  end

  // one-hot selects straight from the region code
  assign sel_module   = (region == AED_REG_MOD);
  assign sel_sram     = (region == AED_REG_SRAM);
  assign sel_external = (region == AED_REG_EXT);

  // ---------------------------------------------------------------------
  // function code, space identification for outside decode
  // ---------------------------------------------------------------------
  always_comb begin
    if (core_cpu_space) begin
      function_code = FC_CPU_SPACE;
    end else if (core_supv) begin
      function_code = core_prog ? FC_SUPV_PROG : FC_SUPV_DATA;
    end else begin
      function_code = core_prog ? FC_USER_PROG : FC_USER_DATA;
    end
  end

  // outputs straight from the same-cycle decode and the lock flag
  assign intermodule_bus_addr = bus_addr;
  assign regs_locked          = locked_q;
  assign reg_base = map_eff ? REG_FULL_BASE : REG_LOW_BASE;

  // ---------------------------------------------------------------------
  // checks on the address path
  // ---------------------------------------------------------------------
  // vector fetches are the only cycles that do not follow the core address
  a_ext_replicate: assert property (
    vec_fetch ||
    intermodule_bus_addr[BUS_AW-1 -: EXT_W] == {EXT_W{core_addr[SIGN_BIT]}})
    else $error("upper bus nibble does not follow bit 19");

  a_hole_unreached: assert property (
    !(intermodule_bus_addr >= HOLE_LO && intermodule_bus_addr <= HOLE_HI))
    else $error("bus address inside the undefined span");

  a_flat_range: assert property (
    !vec_fetch |-> intermodule_bus_addr[CORE_AW-1:0] == core_addr)
    else $error("low bus address differs from core address");

  a_vector_bank: assert property (
    vec_fetch |-> intermodule_bus_addr == {BANK0, BANK0, vec_offset})
    else $error("vector fetch left bank 0");

  // ---------------------------------------------------------------------
  // checks on the register base and its lock
  // ---------------------------------------------------------------------
  // the lock has two steps: the cleared bit, then a flag that never drops
  sequence s_map_cleared;
    !module_map_select;
  endsequence

  sequence s_locked_after;
    ##1 regs_locked;
  endsequence

  a_base_nibble: assert property (
    reg_base[BUS_AW-1 -: EXT_W] ==
      {module_map_select && !regs_locked, REG_NIB_LOW})
    else $error("register base nibble wrong");

  a_base_aligned: assert property (
    (reg_base & ~REG_BLK_MASK) == '0)
    else $error("register base has bits below the nibble");

  a_lock_sticky: assert property (
    s_map_cleared |-> s_locked_after ##1 regs_locked)
    else $error("register lock not held after mapping bit cleared");

  // only reset may drop the lock, so a set flag is still set next edge
  a_lock_hold: assert property (
    regs_locked |=> regs_locked)
    else $error("register lock dropped without reset");

  a_locked_unsel: assert property (
    ((!module_map_select || regs_locked) && cyc_valid) |-> !sel_module)
    else $error("module registers reachable at low base");

  // ---------------------------------------------------------------------
  // checks on the region decode and the function code
  // ---------------------------------------------------------------------
  a_ext_default: assert property (
    (cyc_valid && !sel_module && !sel_sram) |-> sel_external)
    else $error("unimplemented block not sent outside");

  // sram only loses to the module window, never to the external bus
  a_sram_hit: assert property (
    (cyc_valid && sram_enable && !sel_module &&
     (intermodule_bus_addr & SRAM_MASK) == (sram_base & SRAM_MASK))
    |-> sel_sram)
    else $error("standby ram base register not honoured");

  a_one_region: assert property (
    cyc_valid |-> $onehot({sel_module, sel_sram, sel_external}))
    else $error("decode not exactly one region");

  a_idle_quiet: assert property (
    !cyc_valid |-> !(sel_module || sel_sram || sel_external))
    else $error("region selected with no bus cycle");

  a_fc_prog: assert property (
    (!core_cpu_space && core_prog) |->
      function_code[1:0] == FC_USER_PROG[1:0])
    else $error("program space code wrong");

  a_fc_cpu: assert property (
    core_cpu_space |-> function_code == FC_CPU_SPACE)
    else $error("cpu space code wrong");

  // the top code bit is what lets outside logic tell the states apart
  a_fc_state: assert property (
    !core_cpu_space |-> function_code[FC_W-1] == core_supv)
    else $error("supervisor state not in function code");

endmodule : aed_decode

/* File: logic/aed_pkg.sv */
// Purpose: constants for the address extension and region decode block
// Assumes: 20-bit core address, 24-bit internal bus address
// Notes:   region sizes not fixed by hardware are plain defaults
package aed_pkg;

  // ---------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------
  localparam int unsigned CORE_AW  = 20;
  localparam int unsigned BUS_AW   = 24;
  localparam int unsigned EXT_W    = 4;
  localparam int unsigned FC_W     = 3;
  localparam int unsigned VEC_W    = 16;

  // ---------------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------------
  localparam int unsigned SIGN_BIT      = 19;
  localparam logic [2:0]  REG_NIB_LOW   = 3'h7;      // low three bits of M111
  localparam logic [23:0] HOLE_LO       = 24'h080000;
  localparam logic [23:0] HOLE_HI       = 24'hF7FFFF;
  localparam logic [23:0] REG_BLK_MASK  = 24'hF00000;
  localparam logic [23:0] REG_LOW_BASE  = 24'h700000;
  localparam logic [23:0] REG_FULL_BASE = 24'hF00000;
  // module register window within the base nibble, 4 KB
  localparam logic [19:0] REG_WIN_OFS   = 20'hFF000;
  localparam logic [19:0] REG_WIN_MASK  = 20'hFF000;
  localparam logic [23:0] SRAM_MASK     = 24'hFFF800;  // 2 KB array
  localparam logic [3:0]  BANK0         = 4'h0;

  // ---------------------------------------------------------------------
  // function code encodings
  // ---------------------------------------------------------------------
  localparam logic [2:0] FC_USER_DATA  = 3'h1;
  localparam logic [2:0] FC_USER_PROG  = 3'h2;
  localparam logic [2:0] FC_SUPV_DATA  = 3'h5;
  localparam logic [2:0] FC_SUPV_PROG  = 3'h6;
  localparam logic [2:0] FC_CPU_SPACE  = 3'h7;

  // region selected by the decode, one-hot
  typedef enum logic [3:0] {
    AED_REG_MOD  = 4'h1,
    AED_REG_SRAM = 4'h2,
    AED_REG_EXT  = 4'h4,
    AED_REG_NONE = 4'h8
  } aed_region_t;

endpackage : aed_pkg

/* File: dv/aed_core_model.sv */
// Purpose: core side model presenting bus cycles to the decode
// Assumes: requests change at the falling clock edge
// Notes:   idle address bus shows the inverse of the request
`timescale 1ns/1ps
module aed_core_model (
  input  wire logic        req_valid,
  input  wire logic [19:0] req_addr,
  input  wire logic [2:0]  req_kind,
  input  wire logic        map_clear,
  output logic             cyc_valid,
  output logic [19:0]      core_addr,
  output logic             core_prog,
  output logic             core_supv,
  output logic             core_cpu_space,
  output logic             module_map_select
);
  // idle bus inverted so a stale address never looks valid
  assign core_addr = req_valid ? req_addr : ~req_addr;
  assign cyc_valid = req_valid;
  // kind picks program or data space and state
  assign {core_cpu_space, core_supv, core_prog} = req_kind;
  // software keeps the mapping bit set unless a test clears it
  assign module_map_select = ~map_clear;
endmodule : aed_core_model

/* File: dv/test_address_extension_decode.sv */
// Purpose: random and corner checks of address extension and decode
// Assumes: outputs are combinational, lock flag one cycle late
// Notes:   expectations come from the bench functions, the locked_exp flag and constant zeros
`timescale 1ns/1ps
module test_address_extension_decode;
  import aed_pkg::*;
  logic        clk = 0;
  logic        arst_n = 0;
  logic        req_valid = 0;
  logic        map_clear = 0;
  logic        locked_exp = 0;
  logic        vec_fetch = 0;
  logic        sram_enable = 0;
  logic [19:0] req_addr = '0;
  logic [2:0]  req_kind = '0;
  logic [15:0] vec_offset = '0;
  logic [23:0] sram_base = '0;
  logic        cyc_valid, core_prog, core_supv, core_cpu_space, mms;
  logic [19:0] core_addr;
  logic [23:0] bus_addr, reg_base;
  logic [2:0]  fc;
  logic        sel_m, sel_s, sel_e, locked;
  int          mismatches = 0;
  int          total_checks = 0;
  logic [19:0] corners [6] = '{20'h00000, 20'h7FFFF, 20'h80000,
                               20'hFF000, 20'hFFFFF, 20'hFEFFF};
  aed_core_model u_core (.req_valid(req_valid), .req_addr(req_addr),
    .req_kind(req_kind), .map_clear(map_clear), .cyc_valid(cyc_valid),
    .core_addr(core_addr), .core_prog(core_prog), .core_supv(core_supv),
    .core_cpu_space(core_cpu_space), .module_map_select(mms));
  aed_decode u_dut (.clk(clk), .arst_n(arst_n), .cyc_valid(cyc_valid),
    .core_addr(core_addr), .core_prog(core_prog), .core_supv(core_supv),
    .core_cpu_space(core_cpu_space), .vec_fetch(vec_fetch),
    .vec_offset(vec_offset), .module_map_select(mms),
    .sram_base(sram_base), .sram_enable(sram_enable),
    .intermodule_bus_addr(bus_addr), .function_code(fc), .sel_module(sel_m),
    .sel_sram(sel_s), .sel_external(sel_e), .regs_locked(locked),
    .reg_base(reg_base));
  initial forever #2 clk = ~clk;
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task stop_test;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  function logic [23:0] exp_bus();
    logic [19:0] a;
    // an idle core shows the inverse of the request on its address lines
    a = vec_fetch ? {4'h0, vec_offset} : (req_valid ? req_addr : ~req_addr);
    return {{4{a[19]}}, a};
  endfunction : exp_bus
  // module window beats sram, anything else goes outside
  function logic [2:0] exp_sel(input logic [23:0] b);
    if (!req_valid) return 3'h0;
    if (!map_clear && !locked_exp && b[23:12] == 12'hFFF) return 3'h4;
    if (sram_enable && (b & SRAM_MASK) == (sram_base & SRAM_MASK))
      return 3'h2;
    return 3'h1;
  endfunction : exp_sel
  // kind bits are cpu space, supervisor, program
  function logic [2:0] exp_fc();
    if (req_kind[2]) return 3'h7;
    return {req_kind[1], req_kind[0], ~req_kind[0]};
  endfunction : exp_fc
  // once locked the base stays low even if the bit comes back
  function logic [23:0] exp_base();
    return (map_clear || locked_exp) ? REG_LOW_BASE : REG_FULL_BASE;
  endfunction : exp_base
  task cyc(input logic [19:0] a, input logic v);
    @(negedge clk);
    req_addr = a;
    req_valid = v | ($urandom % 4 != 0);
    req_kind = ($urandom % 5 == 4) ? 3'h4 : 3'($urandom % 4);
    vec_fetch = ($urandom % 8 == 0);
    vec_offset = 16'($urandom);
    sram_enable = 1'($urandom);
    // half the cycles aim the standby ram base at the address itself
    sram_base = ($urandom % 2) ? exp_bus() ^ (24'($urandom) & ~SRAM_MASK) :
      24'($urandom);
    #1;
    chk(bus_addr, exp_bus());
    chk(24'(bus_addr >= HOLE_LO && bus_addr <= HOLE_HI), 24'h0);
    chk(24'(fc), 24'(exp_fc()));
    chk(24'({sel_m, sel_s, sel_e}), 24'(exp_sel(exp_bus())));
    chk(reg_base, exp_base());
    chk(24'(locked), 24'(locked_exp));
  endtask : cyc
  initial begin
    void'($urandom(20935));
    repeat (8) @(posedge clk);
    @(negedge clk) arst_n = 1;
    foreach (corners[i]) cyc(corners[i], 1'b1);
    repeat (400) cyc(20'($urandom), 1'b0);
    // clearing the mapping bit hides the module window until reset
    @(negedge clk) map_clear = 1;
    locked_exp = 1;
    foreach (corners[i]) cyc(corners[i], 1'b1);
    // setting the bit again must not bring the window back
    @(negedge clk) map_clear = 0;
    foreach (corners[i]) cyc(corners[i], 1'b1);
    @(negedge clk) arst_n = 0;
    #1 chk(24'(locked), 24'h0);
    locked_exp = 0;
    @(negedge clk) arst_n = 1;
    foreach (corners[i]) cyc(corners[i], 1'b1);
    stop_test();
  end
  // watchdog well beyond the under 2000 ns the tests need
  initial begin
    #20000;
    mismatches++;
    stop_test();
  end
endmodule : test_address_extension_decode
